// ---- logic/dpll_phase_cfg.svh ----
// constants for the coarse phase detector configuration block
// assumes one includer per compile unit; guard prevents double definition
`ifndef DPLL_PHASE_CFG_SVH
`define DPLL_PHASE_CFG_SVH

// register byte addresses
`define COARSE_CFG_ADDR     8'h74
`define COARSE_STATUS_ADDR  8'h78

// configuration register reset and field positions
`define COARSE_CFG_RESET    8'h85
`define CFG_UNUSED_MASK     8'hEF
`define LOSS_EN_BIT         7
`define WIDE_EN_BIT         6
`define FULL_SPAN_BIT       5
`define LIMIT_HI            3
`define LIMIT_LO            0

// status register field positions
`define ST_COUNT_LO         16
`define ST_LOSS_BIT         2
`define ST_LOCK_BIT         1
`define ST_MODE_BIT         0

// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ---- logic/dpll_phase_pkg.sv ----
// types shared by the coarse phase detector configuration block
// assumes no other package; constants live in dpll_phase_cfg.svh
package dpll_phase_pkg;
   typedef logic [1:0] axi_resp_t;
   // which phase result feeds the loop filter
   typedef enum logic {PH_LIMITED, PH_FULL_SPAN} phase_mode_t;
endpackage : dpll_phase_pkg

// ---- logic/dpll_coarse_phase_detector_cfg.sv ----
// coarse phase detector configuration and phase result selection
// assumes slip pulses and fine phase come from logic on core_clk
//
// How it works
// - wide bit enables wide phase and lock detector; clear turns it off
// - full span bit clear limits loop phase to plus or minus one cycle
// - full span bit set passes whole coarse measurement for faster pull-in
// - limited response trades slower pull-in for less overshoot
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dpll_phase_cfg.svh"

module dpll_coarse_phase_detector_cfg #(
   parameter int COUNT_W = 14,
   parameter int FRAC_W  = 8
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   input  wire logic [7:0]                 s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [7:0]                 s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       slip_up,
   input  wire logic                       slip_down,
   input  wire logic [FRAC_W-1:0]          fine_phase,
   output logic                            wide_detector_en,
   output logic                            wide_lock,
   output logic                            coarse_phase_loss,
   output logic signed [COUNT_W+FRAC_W-1:0] loop_phase
);

   localparam int PW = COUNT_W + FRAC_W;

   // configuration byte and bus state
   logic [7:0]             coarse_phase_loss_config;
   logic                   aw_held;
   logic                   w_held;
   logic [7:0]             aw_addr;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;
   logic signed [COUNT_W-1:0] cycle_count;
   logic signed [PW-1:0]   full_phase;
   logic signed [PW-1:0]   next_loop_phase;
   logic signed [COUNT_W-1:0] next_cycle_count;
   logic [COUNT_W-1:0]     count_mag;
   logic [31:0]            status_word;
   logic [31:0]            next_rdata;
   logic                   do_write;
   logic                   hit_cfg_w;
   logic                   hit_st_w;
   logic                   hit_cfg_r;
   logic                   hit_st_r;
   logic                   wide_en;
   logic                   loss_en;
   logic [3:0]             loss_limit;
   dpll_phase_pkg::phase_mode_t mode;

   localparam logic signed [COUNT_W-1:0] CNT_MAX =
      {1'b0, {(COUNT_W-1){1'b1}}};
   localparam logic signed [COUNT_W-1:0] CNT_MIN =
      {1'b1, {(COUNT_W-1){1'b0}}};
   localparam logic signed [PW-1:0] ONE_CYCLE =
      PW'(1) <<< FRAC_W;

   // word-aligned address match, reused by read and write decode
   function automatic logic addr_hit(input logic [7:0] a,
                                     input logic [7:0] reg_addr);
      addr_hit = (a[7:2] == reg_addr[7:2]);
   endfunction : addr_hit

   // field decode of the configuration byte
   assign wide_en    = coarse_phase_loss_config[`WIDE_EN_BIT];
   assign loss_en    = coarse_phase_loss_config[`LOSS_EN_BIT];
   assign loss_limit = coarse_phase_loss_config[`LIMIT_HI:`LIMIT_LO];
   assign mode       = coarse_phase_loss_config[`FULL_SPAN_BIT] ?
                       dpll_phase_pkg::PH_FULL_SPAN :
                       dpll_phase_pkg::PH_LIMITED;
   assign wide_detector_en = wide_en;

   // bus decode
   assign hit_cfg_w = addr_hit(aw_addr, `COARSE_CFG_ADDR);
   assign hit_st_w  = addr_hit(aw_addr, `COARSE_STATUS_ADDR);
   assign hit_cfg_r = addr_hit(s_axi_araddr, `COARSE_CFG_ADDR);
   assign hit_st_r  = addr_hit(s_axi_araddr, `COARSE_STATUS_ADDR);
   assign do_write  = aw_held && w_held && !s_axi_bvalid;

   // one write outstanding: stop taking until the response drains
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // write address and data captured in either order
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // register update and write response; status writes are ignored
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         coarse_phase_loss_config <= `COARSE_CFG_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (do_write) begin
            if (hit_cfg_w && w_strb[0]) begin
               // bit 4 is unused and always stored as zero
               coarse_phase_loss_config <= w_data[7:0] & `CFG_UNUSED_MASK;
            end
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (hit_cfg_w || hit_st_w) ?
                            `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read data mux; unmapped reads return zero with an error
   // count sits from bit 16 up; a wider count is cut at the word's top
   assign status_word = 32'({cycle_count,
                             {(`ST_COUNT_LO - `ST_LOSS_BIT - 1){1'b0}},
                             coarse_phase_loss, wide_lock,
                             mode == dpll_phase_pkg::PH_FULL_SPAN});
   assign next_rdata  = hit_cfg_r ? {24'h00_0000, coarse_phase_loss_config}
                      : hit_st_r  ? status_word
                      : 32'h0000_0000;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= (hit_cfg_r || hit_st_r) ?
                         `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // whole-cycle tracker: counts slips only while the wide detector runs,
   // saturating so a runaway input cannot wrap the phase sign
   always_comb begin
      next_cycle_count = cycle_count;
      if (!wide_en) begin
         next_cycle_count = '0;
      end else if (slip_up && !slip_down && cycle_count != CNT_MAX) begin
         next_cycle_count = cycle_count + COUNT_W'(1);
      end else if (slip_down && !slip_up && cycle_count != CNT_MIN) begin
         next_cycle_count = cycle_count - COUNT_W'(1);
      end
   end

   // full measurement in cycles and fraction of a cycle
   assign full_phase = {cycle_count, fine_phase};
   assign count_mag  = cycle_count[COUNT_W-1] ?
                       COUNT_W'(-cycle_count) : COUNT_W'(cycle_count);

   // phase handed to the loop filter
   always_comb begin
      next_loop_phase = full_phase;
      if (mode == dpll_phase_pkg::PH_FULL_SPAN) begin
         // large error reaches the filter whole for fast pull-in
         next_loop_phase = full_phase;
      end else if (full_phase > ONE_CYCLE) begin
         // clamped error slows pull-in but limits overshoot
         next_loop_phase = ONE_CYCLE;
      end else if (full_phase < -ONE_CYCLE) begin
         next_loop_phase = -ONE_CYCLE;
      end
   end

   // tracker keeps the true phase in both modes; only the result is clamped
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cycle_count       <= '0;
         loop_phase        <= '0;
         wide_lock         <= 1'b0;
         coarse_phase_loss <= 1'b0;
      end else begin
         cycle_count <= next_cycle_count;
         loop_phase  <= next_loop_phase;
         // lock means input within the current cycle of the output
         wide_lock   <= wide_en && (next_cycle_count == '0);
         coarse_phase_loss <= loss_en && wide_en &&
                              (count_mag > COUNT_W'(loss_limit));
      end
   end

endmodule : dpll_coarse_phase_detector_cfg

`default_nettype wire

// ---- bench/phase_cfg_sva.sv ----
// port checker for the coarse phase detector config block
// assumes it is bound onto the block top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module phase_cfg_sva #(
   parameter int COUNT_W = 14,
   parameter int FRAC_W  = 8
) (
   input wire logic                         core_clk,
   input wire logic                         rst_n,
   input wire logic                         s_axi_awready,
   input wire logic [1:0]                   s_axi_bresp,
   input wire logic                         s_axi_bvalid,
   input wire logic                         s_axi_bready,
   input wire logic                         s_axi_arvalid,
   input wire logic                         s_axi_arready,
   input wire logic [31:0]                  s_axi_rdata,
   input wire logic                         s_axi_rvalid,
   input wire logic                         s_axi_rready,
   input wire logic [FRAC_W-1:0]            fine_phase,
   input wire logic                         wide_detector_en,
   input wire logic                         wide_lock,
   input wire logic                         coarse_phase_loss,
   input wire logic signed [COUNT_W+FRAC_W-1:0] loop_phase
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // count is forced to zero one edge after the detector goes off; loop phase follows one edge later
   sequence wide_off3;
      !wide_detector_en [*3];
   endsequence
   a_off_no_lock: assert property (!wide_detector_en |=> !wide_lock)
      else $error("lock while detector off");
   a_off_no_loss: assert property (
      !wide_detector_en |=> !coarse_phase_loss)
      else $error("loss while detector off");
   a_off_fine_only: assert property (wide_off3 |->
      $unsigned(loop_phase) == $past(fine_phase))
      else $error("loop phase not fine only");
   a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during response");
   a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'h0)
      else $error("bad write response code");
endmodule : phase_cfg_sva
bind dpll_coarse_phase_detector_cfg phase_cfg_sva #(
   .COUNT_W(COUNT_W), .FRAC_W(FRAC_W)) chk_u (.*);
`default_nettype wire

// ---- bench/test_dpll_coarse_phase_detector_cfg.sv ----
// register bench for the coarse phase detector config block
// assumes design files compiled first; drives every port itself
`timescale 1ns/100ps
`default_nettype none
`include "dpll_phase_cfg.svh"
module test_dpll_coarse_phase_detector_cfg;
   logic        core_clk, rst_n, slip_up, slip_down, s_axi_awvalid;
   logic        s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, wide_detector_en, wide_lock, coarse_phase_loss;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, fine_phase;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [21:0] loop_phase;
   int          error_cnt = 0;
   int          cmp_count = 0;
   dpll_coarse_phase_detector_cfg dut_u (.*);
   initial begin
      core_clk = 1'h0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic end_of_test;
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk
   // values are looked at on the falling edge, taken on the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic ta, tw, tv, tb;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      // bready follows bvalid late so the response must wait one cycle
      for (int n = 0; n < 20; n++) begin
         @(negedge core_clk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tv = s_axi_bvalid;
         tb = tv & s_axi_bready;
         rs = s_axi_bresp;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tb) begin
            s_axi_bready <= 1'h0;
            return;
         end
         if (tv) s_axi_bready <= 1'h1;
      end
      error_cnt++;
      end_of_test();
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      logic ta, tv, tr;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      for (int n = 0; n < 20; n++) begin
         @(negedge core_clk);
         ta = s_axi_arvalid & s_axi_arready;
         tv = s_axi_rvalid;
         tr = tv & s_axi_rready;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'h0;
         if (tr) begin
            s_axi_rready <= 1'h0;
            return;
         end
         if (tv) s_axi_rready <= 1'h1;
      end
      error_cnt++;
      end_of_test();
   endtask : rdr
   // one-cycle slip pulses, spaced, then let count and phase settle
   task automatic slp(input logic up, input int n);
      repeat (n) begin
         @(posedge core_clk);
         slip_up <= up;
         slip_down <= !up;
         @(posedge core_clk);
         slip_up <= 1'h0;
         slip_down <= 1'h0;
      end
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
   endtask : slp
   initial begin
      {rst_n, slip_up, slip_down, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      fine_phase = 8'h80;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'h1;
      rdr(`COARSE_CFG_ADDR);
      chk(rd, 32'h00000085);
      chk({31'h0, wide_detector_en}, 32'h0);
      wr(`COARSE_CFG_ADDR, 32'h00000040, 4'hF);
      slp(1'h1, 3);
      chk({31'h0, wide_detector_en}, 32'h1);
      chk({10'h0, loop_phase}, 32'h00000100);
      slp(1'h0, 6);
      chk({10'h0, loop_phase}, 32'h003FFF00);
      wr(`COARSE_CFG_ADDR, 32'h00000060, 4'hF);
      slp(1'h0, 0);
      chk({10'h0, loop_phase}, 32'h003FFD80);
      rdr(`COARSE_STATUS_ADDR);
      chk(rd & 32'h00000007, 32'h00000001);
      wr(`COARSE_CFG_ADDR, 32'h000000F5, 4'h0);
      chk({30'h0, rs}, {30'h0, `RESP_OKAY});
      rdr(`COARSE_CFG_ADDR);
      chk(rd, 32'h00000060);
      rdr(8'h10);
      chk({rs, rd[29:0]}, {`RESP_SLVERR, 30'h0});
      wr(`COARSE_CFG_ADDR, 32'h00000000, 4'hF);
      slp(1'h1, 2);
      chk({10'h0, loop_phase}, 32'h00000080);
      // loss limit of two whole cycles, then back to zero for lock
      wr(`COARSE_CFG_ADDR, 32'h000000C2, 4'hF);
      slp(1'h1, 3);
      chk({30'h0, coarse_phase_loss, wide_lock}, 32'h00000002);
      slp(1'h0, 3);
      rdr(`COARSE_STATUS_ADDR);
      chk(rd & 32'h00000007, 32'h00000002);
      wr(8'h10, 32'h00000000, 4'hF);
      chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
      end_of_test();
   end
endmodule : test_dpll_coarse_phase_detector_cfg
`default_nettype wire
